// ---- rtl/dpbm_consts.svh ----
`ifndef DPBM_CONSTS_SVH
`define DPBM_CONSTS_SVH

// Pin ownership selections for the shared pins.
`define DPBM_OWNER_GPIO 2'h0
`define DPBM_OWNER_SLAVE 2'h1
`define DPBM_OWNER_DISP 2'h2

// Signalling style selections.
`define DPBM_STYLE_8080 1'h0
`define DPBM_STYLE_6800 1'h1

// Access phase lengths, in nanoseconds, and derived clock counts at 25 ns.
`define DPBM_CLK_NS 25
`define DPBM_SETUP_NS 50
`define DPBM_STROBE_NS 100
`define DPBM_HOLD_NS 50
`define DPBM_SETUP_CYC ((`DPBM_SETUP_NS + `DPBM_CLK_NS - 1) / `DPBM_CLK_NS)
`define DPBM_STROBE_CYC ((`DPBM_STROBE_NS + `DPBM_CLK_NS - 1) / `DPBM_CLK_NS)
`define DPBM_HOLD_CYC ((`DPBM_HOLD_NS + `DPBM_CLK_NS - 1) / `DPBM_CLK_NS)
`define DPBM_CNT_W 4

`endif

// ---- rtl/dpbm_pkg.sv ----
`default_nettype none
package dpbm_pkg;

typedef enum logic [1:0] {st_idle, st_setup, st_strobe, st_hold} dpbm_state_type;

typedef struct packed {
    logic read;
    logic reg_sel;
    logic [7:0] wdata;
} dpbm_req_type;

typedef struct packed {
    logic [7:0] data_out;
    logic data_oe_n;
    logic read_or_enable;
    logic write_or_rw;
    logic chip_select_n;
    logic reg_select;
} dpbm_pins_type;

typedef struct packed {
    dpbm_state_type state;
    logic [3:0] count;
    dpbm_req_type req;
    dpbm_pins_type pins;
    logic style;
    logic ready;
    logic own;
    logic done;
    logic [7:0] rdata;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] sync3;
    logic [7:0] bus_seen;
} dpbm_regs_type;

endpackage
`default_nettype wire

// ---- rtl/dpbm_master.sv ----
// Behaviour
// [R1] 8080: read strobe low during reads
// [R2] 6800: enable high during every access
// [R3] 8080: write strobe low during writes
// [R4] 6800: rw low write, high read
// [R5] Chip select low during access only
// [R6] Register select held whole access
// [R7] Drive data on write, release on read
// [R8] Style select; own pins when selected or while an access is in progress
`timescale 1ns/1ps
`default_nettype none
`include "dpbm_consts.svh"

module dpbm_master (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [1:0] pin_owner,
    input wire logic style_6800,
    input wire logic req_valid,
    input wire dpbm_pkg::dpbm_req_type req,
    output logic req_ready,
    output logic rsp_done,
    output logic [7:0] rsp_rdata,
    input wire logic [7:0] disp_data_bus_in,
    output var dpbm_pkg::dpbm_pins_type disp_pins,
    output logic disp_own
);

    dpbm_pkg::dpbm_regs_type r;
    dpbm_pkg::dpbm_regs_type next_r;
    logic owned;

    // ------------------------------------------------------------
    // Idle pin levels
    // ------------------------------------------------------------
    function automatic dpbm_pkg::dpbm_pins_type idle_pins(input logic style);
        dpbm_pkg::dpbm_pins_type p;
        p.data_out = 8'h00;
        p.data_oe_n = 1'b1;
        p.read_or_enable = (style == `DPBM_STYLE_6800) ? 1'b0 : 1'b1;
        p.write_or_rw = 1'b1;
        p.chip_select_n = 1'b1;
        p.reg_select = 1'b0;
        return p;
    endfunction

    assign owned = (pin_owner == `DPBM_OWNER_DISP); // R8

    // ------------------------------------------------------------
    // Access sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        next_r = r;
        next_r.done = 1'b0;
        // The display bus comes from pins; a byte counts once two stages agree.
        next_r.sync1 = disp_data_bus_in;
        next_r.sync2 = r.sync1;
        next_r.sync3 = r.sync2;
        if (r.sync2 == r.sync3)
        begin
            next_r.bus_seen = r.sync3;
        end
        next_r.own = owned || (r.state != dpbm_pkg::st_idle); // R8
        case (r.state)
            dpbm_pkg::st_idle:
            begin
                next_r.style = style_6800; // R8
                next_r.pins = idle_pins(style_6800);
                next_r.ready = 1'b1;
                if (req_valid && owned)
                begin
                    next_r.req = req;
                    next_r.ready = 1'b0;
                    next_r.state = dpbm_pkg::st_setup;
                    next_r.count = 4'(`DPBM_SETUP_CYC - 1);
                    next_r.pins.chip_select_n = 1'b0; // R5
                    next_r.pins.reg_select = req.reg_sel; // R6
                    next_r.pins.data_out = req.wdata;
                    next_r.pins.data_oe_n = req.read; // R7
                    if (style_6800 == `DPBM_STYLE_6800)
                    begin
                        next_r.pins.write_or_rw = req.read; // R4
                    end
                end
            end
            dpbm_pkg::st_setup:
            begin
                if (r.count == 4'h0)
                begin
                    next_r.state = dpbm_pkg::st_strobe;
                    next_r.count = 4'(`DPBM_STROBE_CYC - 1);
                    if (r.style == `DPBM_STYLE_6800)
                    begin
                        next_r.pins.read_or_enable = 1'b1; // R2
                    end
                    else if (r.req.read)
                    begin
                        next_r.pins.read_or_enable = 1'b0; // R1
                    end
                    else
                    begin
                        next_r.pins.write_or_rw = 1'b0; // R3
                    end
                end
                else
                begin
                    next_r.count = r.count - 4'h1;
                end
            end
            dpbm_pkg::st_strobe:
            begin
                if (r.count == 4'h0)
                begin
                    next_r.state = dpbm_pkg::st_hold;
                    next_r.count = 4'(`DPBM_HOLD_CYC - 1);
                    next_r.rdata = r.bus_seen;
                    next_r.pins.read_or_enable = (r.style == `DPBM_STYLE_6800) ? 1'b0 : 1'b1;
                    if (r.style == `DPBM_STYLE_8080)
                    begin
                        next_r.pins.write_or_rw = 1'b1;
                    end
                end
                else
                begin
                    next_r.count = r.count - 4'h1;
                end
            end
            dpbm_pkg::st_hold:
            begin
                if (r.count == 4'h0)
                begin
                    next_r.state = dpbm_pkg::st_idle;
                    next_r.pins = idle_pins(r.style); // R5
                    next_r.done = 1'b1;
                    next_r.ready = 1'b1;
                end
                else
                begin
                    next_r.count = r.count - 4'h1;
                end
            end
            default:
            begin
                next_r.state = dpbm_pkg::st_idle;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            r.state <= dpbm_pkg::st_idle;
            r.count <= 4'h0;
            r.req <= '0;
            r.pins <= {8'h00, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
            r.style <= `DPBM_STYLE_8080;
            r.ready <= 1'b1;
            r.own <= 1'b0;
            r.done <= 1'b0;
            r.rdata <= 8'h00;
            r.sync1 <= 8'h00;
            r.sync2 <= 8'h00;
            r.sync3 <= 8'h00;
            r.bus_seen <= 8'h00;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign req_ready = r.ready;
    assign rsp_done = r.done;
    assign rsp_rdata = r.rdata;
    assign disp_pins = r.pins;
    assign disp_own = r.own;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_rd8080;
        @(posedge clk) disable iff (sys_rst)
        (r.state == dpbm_pkg::st_strobe && r.style == 1'b0 && r.req.read)
        |-> !disp_pins.read_or_enable && disp_pins.write_or_rw;
    endproperty
    a_rd8080: assert property (p_rd8080) else $error("8080 read strobe wrong"); // R1

    property p_en6800;
        @(posedge clk) disable iff (sys_rst)
        (r.state == dpbm_pkg::st_strobe && r.style == 1'b1) |-> disp_pins.read_or_enable;
    endproperty
    a_en6800: assert property (p_en6800) else $error("6800 enable not high"); // R2

    property p_wr8080;
        @(posedge clk) disable iff (sys_rst)
        (r.state == dpbm_pkg::st_strobe && r.style == 1'b0 && !r.req.read)
        |-> !disp_pins.write_or_rw && disp_pins.read_or_enable;
    endproperty
    a_wr8080: assert property (p_wr8080) else $error("8080 write strobe wrong"); // R3

    property p_rw6800;
        @(posedge clk) disable iff (sys_rst)
        (r.style == 1'b1 && !disp_pins.chip_select_n) |-> disp_pins.write_or_rw == r.req.read;
    endproperty
    a_rw6800: assert property (p_rw6800) else $error("6800 rw level wrong"); // R4

    property p_cs;
        @(posedge clk) disable iff (sys_rst)
        disp_pins.chip_select_n == (r.state == dpbm_pkg::st_idle);
    endproperty
    a_cs: assert property (p_cs) else $error("chip select mismatch"); // R5

    property p_rs;
        @(posedge clk) disable iff (sys_rst)
        (!disp_pins.chip_select_n && $past(!disp_pins.chip_select_n))
        |-> $stable(disp_pins.reg_select);
    endproperty
    a_rs: assert property (p_rs) else $error("register select moved"); // R6

    property p_data;
        @(posedge clk) disable iff (sys_rst)
        !disp_pins.chip_select_n |-> disp_pins.data_oe_n == r.req.read;
    endproperty
    a_data: assert property (p_data) else $error("data drive wrong"); // R7

    property p_own;
        @(posedge clk) disable iff (sys_rst)
        (req_valid && req_ready && !owned && r.state == dpbm_pkg::st_idle)
        |=> r.state == dpbm_pkg::st_idle;
    endproperty
    a_own: assert property (p_own) else $error("access without pin ownership"); // R8

endmodule

`default_nettype wire

// ---- test/dpbm_disp_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module dpbm_disp_model (
    input wire logic clk,
    input wire dpbm_pkg::dpbm_pins_type pins,
    output logic [7:0] bus_in
);
    logic [7:0] stored = 8'h00;
    logic [7:0] last = 8'h00;
    always @(posedge clk)
    begin
        if (!pins.chip_select_n && !pins.data_oe_n)
            stored <= pins.data_out;
        last <= bus_in;
    end
    // Outside a selected read the bus shows a value that changes every cycle.
    assign bus_in = (!pins.chip_select_n && pins.data_oe_n) ? stored : ~last;
endmodule
`default_nettype wire

// ---- test/display_parallel_bus_master_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module display_parallel_bus_master_tb_top;
    typedef struct packed {
        logic read;
        logic rs;
        logic style;
        logic [7:0] data;
    } dpbm_note_type;
    logic clk;
    logic sys_rst;
    logic [1:0] pin_owner;
    logic style_6800;
    logic req_valid;
    dpbm_pkg::dpbm_req_type req;
    logic req_ready;
    logic rsp_done;
    logic [7:0] rsp_rdata;
    logic [7:0] bus_in;
    dpbm_pkg::dpbm_pins_type pins;
    logic own;
    int mismatches = 0;
    int compares = 0;
    int strobes = 0;
    logic [7:0] lfsr = 8'h49;
    logic [7:0] last_wr = 8'h00;
    dpbm_note_type notes[$];
    dpbm_note_type n;
    dpbm_master dut (.clk(clk), .sys_rst(sys_rst), .pin_owner(pin_owner),
        .style_6800(style_6800), .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .rsp_done(rsp_done), .rsp_rdata(rsp_rdata), .disp_data_bus_in(bus_in),
        .disp_pins(pins), .disp_own(own));
    dpbm_disp_model disp (.clk(clk), .pins(pins), .bus_in(bus_in));
    always #12.5 clk = ~clk;
    function automatic logic [7:0] lfsr_next(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task complete_run;
        $display("mismatches=%0d compares=%0d", mismatches, compares);
        if (mismatches == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task send(input logic rd, input logic rs, input logic [7:0] d);
        int k;
        k = 0;
        while (req_ready !== 1'b1 && k < 50)
        begin
            @(posedge clk);
            #1;
            k++;
        end
        req_valid = 1'b1;
        req = '{read: rd, reg_sel: rs, wdata: d};
        notes.push_back('{read: rd, rs: rs, style: style_6800, data: rd ? last_wr : d});
        if (!rd)
            last_wr = d;
        @(posedge clk);
        #1;
        req_valid = 1'b0;
    endtask
    always @(posedge clk)
    begin
        if (!sys_rst && notes.size() == 0)
            chk("cs_n_idle", pins.chip_select_n, 1);
        if (!sys_rst && notes.size() > 0 && !pins.chip_select_n)
        begin
            chk("reg_select", pins.reg_select, notes[0].rs);
            if (notes[0].style ? pins.read_or_enable === 1'b1 :
                (notes[0].read ? pins.read_or_enable : pins.write_or_rw) === 1'b0)
            begin
                strobes++;
                chk("oe_n", pins.data_oe_n, notes[0].read);
                if (!notes[0].read)
                    chk("data_out", pins.data_out, notes[0].data);
                if (notes[0].style)
                    chk("rw", pins.write_or_rw, notes[0].read);
                else
                    chk("idle_strobe", notes[0].read ? pins.write_or_rw : pins.read_or_enable, 1);
            end
        end
        if (rsp_done === 1'b1)
        begin
            if (notes.size() == 0)
                chk("spurious_done", 1, 0);
            else
            begin
                n = notes.pop_front();
                chk("strobe_cycles", 8'(strobes), 4);
                if (n.read)
                    chk("rdata", rsp_rdata, n.data);
            end
            strobes = 0;
        end
    end
    initial
    begin
        #20000;
        mismatches++;
        complete_run();
    end
    initial
    begin
        clk = 0;
        sys_rst = 1;
        pin_owner = 2'h2;
        style_6800 = 0;
        req_valid = 0;
        req = '0;
        repeat (3) @(posedge clk);
        #1;
        sys_rst = 0;
        for (int s = 0; s < 2; s++)
        begin
            style_6800 = s[0];
            for (int i = 0; i < 4; i++)
            begin
                lfsr = lfsr_next(lfsr);
                send(i[0], lfsr[7], lfsr);
            end
        end
        repeat (12) @(posedge clk);
        #1;
        chk("own", own, 1);
        pin_owner = 2'h0;
        req_valid = 1'b1;
        repeat (12) @(posedge clk);
        #1;
        chk("own", own, 0);
        req_valid = 1'b0;
        pin_owner = 2'h2;
        @(posedge clk);
        #1;
        send(1'b1, 1'b0, 8'h00);
        repeat (12) @(posedge clk);
        complete_run();
    end
endmodule
`default_nettype wire
